// >>> rtl/electronic_gear_phasing.sv
// Summary of operation
// - source 0 off, 1 encoder1, 2 encoder2
// - source 11 takes bus word, extrapolates
// - sync decode; mode off at start errors with source 11
// - mode 1 syncs on telegram or sync
// - modes 2 and 3 do no extrapolation
// - signed numerator over unsigned denominator ratio
// - resync 0: ratio change not ramped
// - resync 1: ramp to new frequency
// - ratio change with resync 1 clears in-gear until reached
// - phasing shifts slave by signed offset
// - start phasing moves until offset reached
// - phasing speed adds to master speed
// - phasing done flag when offset reached
// - start dropped: ramp back, then done
`timescale 1ns/1ps
module electronic_gear_phasing (
   // clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    arst_n_in,
   // control cycle tick
   input  wire logic                    cycle_tick_in,
   // configuration
   input  wire logic [7:0]              master_source_in,
   input  wire logic [7:0]              sync_mode_in,
   input  wire gear_pkg::gear_ratio_t   ratio_in,
   input  wire logic                    ratio_change_resync_in,
   input  wire logic [31:0]             ramp_accel_in,
   input  wire gear_pkg::phasing_cfg_t  phasing_cfg_in,
   input  wire logic                    start_phasing_in,
   input  wire logic                    slave_start_in,
   // master inputs
   input  wire gear_pkg::master_sample_t enc1_in,
   input  wire gear_pkg::master_sample_t enc2_in,
   // system bus receive
   input  wire logic [31:0]             bus_receive_object1_long_word_in,
   input  wire logic                    bus_rx1_valid_in,
   output logic                         bus_rx1_ready_out,
   input  wire logic                    bus_rx2_in,
   input  wire logic                    bus_rx3_in,
   input  wire logic                    bus_sync_in,
   // outputs
   output logic signed [31:0]           slave_pos_out,
   output logic signed [31:0]           slave_spd_out,
   output logic                         in_gear_out,
   output logic                         phasing_done_out,
   output logic                         sync_error_out,
   output logic                         sync_event_out
);
   // ************************************************
   // bus fifo
   // ************************************************
   logic [31:0] fifo_data_w;
   logic        fifo_valid_w;
   logic        fifo_pop_w;
   word_fifo #(
      .WIDTH (gear_pkg::FIFO_WIDTH),
      .DEPTH (gear_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_in       (clk_in),
      .arst_n_in    (arst_n_in),
      .wr_data_in   (bus_receive_object1_long_word_in),
      .wr_valid_in  (bus_rx1_valid_in),
      .wr_ready_out (bus_rx1_ready_out),
      .rd_data_out  (fifo_data_w),
      .rd_valid_out (fifo_valid_w),
      .rd_ready_in  (fifo_pop_w)
   );
   // ************************************************
   // synchronization decode
   // ************************************************
   // sync mode decode
   wire sync_off_w = (sync_mode_in == gear_pkg::SYNC_OFF);
   wire sync_ev_w = ((sync_mode_in == gear_pkg::SYNC_RX1) && (fifo_valid_w || bus_sync_in))
                 || ((sync_mode_in == gear_pkg::SYNC_RX2) && bus_rx2_in)
                 || ((sync_mode_in == gear_pkg::SYNC_RX3) && bus_rx3_in)
                 || ((sync_mode_in == gear_pkg::SYNC_TELEG) && bus_sync_in);
   wire extrap_ok_w = (sync_mode_in == gear_pkg::SYNC_RX1)
                   || (sync_mode_in == gear_pkg::SYNC_TELEG);
   wire bus_src_w = (master_source_in == gear_pkg::SRC_BUS_EXTR);
   assign fifo_pop_w = fifo_valid_w && (!bus_src_w || sync_mode_in == gear_pkg::SYNC_RX1
                     || sync_ev_w || sync_off_w);
   // ************************************************
   // bus extrapolation
   // ************************************************
   logic signed [31:0] bus_pos_reg;
   logic signed [31:0] bus_rate_reg;
   logic signed [31:0] bus_cnt_reg;
   logic signed [31:0] bus_est_reg;
   wire  signed [31:0] bus_word_w  = fifo_data_w;
   wire  signed [31:0] bus_delta_w = bus_word_w - bus_pos_reg;
   wire  signed [31:0] bus_cnt_div_w = (bus_cnt_reg == 32'sh0) ? 32'sh1 : bus_cnt_reg;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bus_pos_reg  <= '0;
         bus_rate_reg <= '0;
         bus_cnt_reg  <= '0;
         bus_est_reg  <= '0;
      end else if (fifo_pop_w) begin
         bus_pos_reg  <= bus_word_w;
         bus_est_reg  <= bus_word_w;
         bus_rate_reg <= extrap_ok_w ? bus_delta_w / bus_cnt_div_w : 32'sh0;
         bus_cnt_reg  <= '0;
      end else if (cycle_tick_in) begin
         bus_cnt_reg  <= bus_cnt_reg + 32'sh1;
         bus_est_reg  <= bus_est_reg + bus_rate_reg;
      end
   end
   // ************************************************
   // master selection
   // ************************************************
   logic signed [31:0] m_pos_w;
   logic signed [31:0] m_spd_w;
   always_comb begin
      case (master_source_in)
         gear_pkg::SRC_ENC1: begin
            m_pos_w = enc1_in.pos;
            m_spd_w = enc1_in.spd;
         end
         gear_pkg::SRC_ENC2: begin
            m_pos_w = enc2_in.pos;
            m_spd_w = enc2_in.spd;
         end
         gear_pkg::SRC_BUS_EXTR: begin
            m_pos_w = bus_est_reg;
            m_spd_w = bus_rate_reg;
         end
         default: begin
            m_pos_w = '0;
            m_spd_w = '0;
         end
      endcase
   end
   wire src_on_w = (master_source_in == gear_pkg::SRC_ENC1)
                || (master_source_in == gear_pkg::SRC_ENC2) || bus_src_w;
   // ************************************************
   // gear ratio
   // ************************************************
   // clamp ratio range
   wire signed [15:0] num_w = (ratio_in.num < -gear_pkg::NUM_MAX) ? -gear_pkg::NUM_MAX
                                                                   : ratio_in.num;
   wire [15:0] den_w = (ratio_in.den < gear_pkg::DEN_MIN) ? gear_pkg::DEN_MIN : ratio_in.den;
   logic signed [31:0] m_pos_last_reg;
   wire  signed [31:0] m_step_w = src_on_w ? m_pos_w - m_pos_last_reg : 32'sh0;
   wire  signed [63:0] step_prod_w = 64'(m_step_w) * 64'(num_w);
   wire  signed [63:0] spd_prod_w  = 64'(m_spd_w) * 64'(num_w);
   wire  signed [31:0] gear_step_w = 32'(step_prod_w / $signed({48'h0, den_w}));
   wire  signed [31:0] gear_spd_w  = 32'(spd_prod_w / $signed({48'h0, den_w}));
   gear_pkg::gear_ratio_t ratio_last_reg;
   wire ratio_chg_w = (ratio_last_reg != ratio_in);
   // ************************************************
   // resynchronization
   // ************************************************
   logic               resync_reg;
   logic signed [31:0] ramp_spd_reg;
   wire  signed [31:0] racc_w = $signed(ramp_accel_in);
   wire  signed [31:0] rdiff_w = gear_spd_w - ramp_spd_reg;
   wire  rdone_w = (rdiff_w <= racc_w) && (rdiff_w >= -racc_w);
   wire  signed [31:0] ramp_next_w = rdone_w ? gear_spd_w
                                   : (rdiff_w > 0 ? ramp_spd_reg + racc_w
                                                  : ramp_spd_reg - racc_w);
   // ************************************************
   // phasing
   // ************************************************
   gear_pkg::ph_state_t ph_state_reg;
   logic signed [31:0]  ph_spd_reg;
   logic signed [31:0]  ph_dist_reg;
   wire  signed [31:0]  ph_acc_w = (phasing_cfg_in.accel < gear_pkg::PH_ACC_MIN)
                                   ? $signed(gear_pkg::PH_ACC_MIN) : $signed(phasing_cfg_in.accel);
   wire  signed [31:0]  ph_vmax_w = $signed(phasing_cfg_in.speed);
   wire  signed [31:0]  ph_left_w = phasing_cfg_in.offset - ph_dist_reg;
   wire  ph_neg_w = ph_left_w < 0;
   wire  signed [31:0]  ph_abs_w = ph_neg_w ? -ph_left_w : ph_left_w;
   wire  signed [31:0]  ph_mag_w = (ph_spd_reg < 0) ? -ph_spd_reg : ph_spd_reg;
   wire  ph_reached_w = (ph_abs_w <= ph_mag_w) || (ph_left_w == 0);
   wire  signed [31:0]  ph_tgt_w = ph_neg_w ? -ph_vmax_w : ph_vmax_w;
   wire  signed [31:0]  ph_up_w = (ph_spd_reg + ph_acc_w > ph_tgt_w) ? ph_tgt_w
                                  : ph_spd_reg + ph_acc_w;
   wire  signed [31:0]  ph_dn_w = (ph_spd_reg - ph_acc_w < ph_tgt_w) ? ph_tgt_w
                                  : ph_spd_reg - ph_acc_w;
   wire  signed [31:0]  ph_back_w = (ph_mag_w <= ph_acc_w) ? 32'sh0
                                  : (ph_spd_reg > 0 ? ph_spd_reg - ph_acc_w
                                                    : ph_spd_reg + ph_acc_w);
   // ************************************************
   // cycle update
   // ************************************************
   wire resync_now_w = resync_reg || (ratio_chg_w && ratio_change_resync_in);
   wire signed [31:0] gear_out_spd_w = resync_now_w ? ramp_next_w : gear_spd_w;
   wire signed [31:0] ramp_pos_step_w = resync_now_w ? ramp_next_w : gear_step_w;
   wire ph_land_w = (ph_state_reg == gear_pkg::PH_RUN) && start_phasing_in && ph_reached_w;
   wire signed [31:0] ph_step_w = ph_land_w ? ph_left_w : ph_spd_reg;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         m_pos_last_reg <= '0;
         ratio_last_reg <= '{num: gear_pkg::NUM_RESET, den: gear_pkg::DEN_RESET};
         resync_reg     <= 1'b0;
         ramp_spd_reg   <= '0;
         slave_pos_out  <= '0;
         slave_spd_out  <= '0;
         in_gear_out    <= 1'b0;
      end else if (cycle_tick_in) begin
         m_pos_last_reg <= m_pos_w;
         ratio_last_reg <= ratio_in;
         slave_pos_out  <= slave_pos_out + ramp_pos_step_w + ph_step_w;
         slave_spd_out  <= gear_out_spd_w + ph_spd_reg;
         if (ratio_chg_w && ratio_change_resync_in) begin
            resync_reg  <= 1'b1;
            ramp_spd_reg <= ramp_next_w;
            in_gear_out <= 1'b0;
         end else if (resync_reg) begin
            ramp_spd_reg <= ramp_next_w;
            if (rdone_w) begin
               resync_reg  <= 1'b0;
               in_gear_out <= src_on_w;
            end
         end else begin
            ramp_spd_reg <= gear_spd_w;
            in_gear_out  <= src_on_w;
         end
      end
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ph_state_reg     <= gear_pkg::PH_IDLE;
         ph_spd_reg       <= '0;
         ph_dist_reg      <= '0;
         phasing_done_out <= 1'b0;
      end else if (cycle_tick_in) begin
         case (ph_state_reg)
            gear_pkg::PH_IDLE: begin
               if (start_phasing_in && !phasing_done_out) begin
                  ph_state_reg <= gear_pkg::PH_RUN;
                  ph_dist_reg  <= '0;
               end else if (!start_phasing_in) begin
                  phasing_done_out <= 1'b0;
               end
            end
            gear_pkg::PH_RUN: begin
               if (!start_phasing_in) begin
                  ph_state_reg <= gear_pkg::PH_BACK;
               end else if (ph_reached_w) begin
                  ph_dist_reg      <= phasing_cfg_in.offset;
                  ph_spd_reg       <= '0;
                  phasing_done_out <= 1'b1;
                  ph_state_reg     <= gear_pkg::PH_IDLE;
               end else begin
                  ph_spd_reg  <= (ph_spd_reg < ph_tgt_w) ? ph_up_w : ph_dn_w;
                  ph_dist_reg <= ph_dist_reg + ph_spd_reg;
               end
            end
            gear_pkg::PH_BACK: begin
               ph_spd_reg  <= ph_back_w;
               ph_dist_reg <= ph_dist_reg + ph_spd_reg;
               if (ph_spd_reg == 0) begin
                  phasing_done_out <= 1'b1;
                  ph_state_reg     <= gear_pkg::PH_IDLE;
               end
            end
            default: begin
               ph_state_reg <= gear_pkg::PH_IDLE;
            end
         endcase
      end
   end
   // ************************************************
   // sync status
   // ************************************************
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync_error_out <= 1'b0;
         sync_event_out <= 1'b0;
      end else begin
         sync_event_out <= sync_ev_w;
         if (slave_start_in && sync_off_w && bus_src_w) begin
            sync_error_out <= 1'b1;
         end else if (!sync_off_w) begin
            sync_error_out <= 1'b0;
         end
      end
   end
endmodule

// >>> shared/gear_pkg.sv
package gear_pkg;
   // ******************************
   // master source selection
   // ******************************
   localparam logic [7:0] SRC_OFF      = 8'h00;
   localparam logic [7:0] SRC_ENC1     = 8'h01;
   localparam logic [7:0] SRC_ENC2     = 8'h02;
   localparam logic [7:0] SRC_BUS_EXTR = 8'h0b;
   // ******************************
   // bus synchronization modes
   // ******************************
   localparam logic [7:0] SYNC_OFF   = 8'h00;
   localparam logic [7:0] SYNC_RX1   = 8'h01;
   localparam logic [7:0] SYNC_RX2   = 8'h02;
   localparam logic [7:0] SYNC_RX3   = 8'h03;
   localparam logic [7:0] SYNC_TELEG = 8'h0a;
   // ******************************
   // reset values and limits
   // ******************************
   localparam logic signed [15:0] NUM_RESET     = 16'sh0001;
   localparam logic signed [15:0] NUM_MAX       = 16'sh7fff;
   localparam logic [15:0]        DEN_RESET     = 16'h0001;
   localparam logic [15:0]        DEN_MIN       = 16'h0001;
   localparam logic signed [31:0] PH_OFS_RESET  = 32'sh00010000;
   localparam logic [31:0]        PH_SPD_RESET  = 32'h00010000;
   localparam logic [31:0]        PH_ACC_RESET  = 32'h00010000;
   localparam logic [31:0]        PH_ACC_MIN    = 32'h00000001;
   localparam int                 FIFO_WIDTH    = 32;
   localparam int                 FIFO_DEPTH    = 16;
   // ******************************
   // carriers
   // ******************************
   typedef struct packed {
      logic signed [31:0] pos;
      logic signed [31:0] spd;
   } master_sample_t;
   typedef struct packed {
      logic signed [15:0] num;
      logic [15:0]        den;
   } gear_ratio_t;
   typedef struct packed {
      logic signed [31:0] offset;
      logic [31:0]        speed;
      logic [31:0]        accel;
   } phasing_cfg_t;
   typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_BACK} ph_state_t;
endpackage

// >>> rtl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             arst_n_in,
   // write side
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   // read side
   output logic [WIDTH-1:0]      rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wp_reg;
   logic [AW:0]      rp_reg;
   logic             ready_reg;
   wire              empty_w = (wp_reg == rp_reg);
   wire              push_w  = wr_valid_in && ready_reg;
   wire              pop_w   = rd_ready_in && !empty_w;
   wire  [AW:0]      wp_next_w = push_w ? wp_reg + 1'b1 : wp_reg;
   wire  [AW:0]      rp_next_w = pop_w ? rp_reg + 1'b1 : rp_reg;
   wire              full_next_w = (wp_next_w[AW] != rp_next_w[AW])
                                && (wp_next_w[AW-1:0] == rp_next_w[AW-1:0]);
   assign wr_ready_out = ready_reg;
   assign rd_valid_out = !empty_w;
   assign rd_data_out  = mem_reg[rp_reg[AW-1:0]];
   always_ff @(posedge clk_in) begin
      if (push_w) begin
         mem_reg[wp_reg[AW-1:0]] <= wr_data_in;
      end
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wp_reg    <= '0;
         rp_reg    <= '0;
         ready_reg <= 1'b1;
      end else begin
         wp_reg    <= wp_next_w;
         rp_reg    <= rp_next_w;
         ready_reg <= !full_next_w;
      end
   end
endmodule

// >>> bench/master_drive_model.sv
`timescale 1ns/1ps
module master_drive_model (
   // clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     arst_n_in,
   // control cycle and motion step
   input  wire logic                     tick_in,
   input  wire logic [31:0]              step_in,
   // encoder samples
   output gear_pkg::master_sample_t      enc1_out,
   output gear_pkg::master_sample_t      enc2_out,
   // bus transmit
   output logic [31:0]                   word_out,
   output logic                          valid_out,
   input  wire logic                     ready_in
);
   // ******************************
   // master motion
   // ******************************
   initial begin
      valid_out = 1'b0;
      word_out = 32'h0;
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enc1_out <= '0;
         enc2_out <= '0;
      end else if (tick_in) begin
         enc1_out <= {enc1_out.pos + step_in, step_in};
         enc2_out <= {enc2_out.pos + (step_in << 1), step_in << 1};
      end
   end
   task automatic send(input logic [31:0] w, input int lim, output logic ok);
      @(posedge clk_in);
      #1 word_out = w;
      valid_out = 1'b1;
      ok = 1'b0;
      repeat (lim) if (!ok) begin
         #1 ok = ready_in;
         @(posedge clk_in);
      end
      #1 valid_out = 1'b0;
      word_out = ~w;
   endtask
endmodule

// >>> bench/electronic_gear_phasing_properties.sv
`timescale 1ns/1ps
module electronic_gear_phasing_properties (
   // clock and reset
   input wire logic                  clk_in,
   input wire logic                  arst_n_in,
   // inputs watched
   input wire logic                  cycle_tick_in,
   input wire logic [7:0]            master_source_in,
   input wire logic [7:0]            sync_mode_in,
   input wire gear_pkg::gear_ratio_t ratio_in,
   input wire logic                  ratio_change_resync_in,
   input wire logic                  slave_start_in,
   input wire logic                  bus_rx2_in,
   input wire logic                  bus_rx3_in,
   input wire logic                  bus_sync_in,
   // outputs watched
   input wire logic                  bus_rx1_ready_out,
   input wire logic signed [31:0]    slave_pos_out,
   input wire logic                  in_gear_out,
   input wire logic                  sync_error_out,
   input wire logic                  sync_event_out
);
   // ******************************
   // properties
   // ******************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   gear_pkg::gear_ratio_t ratio_seen;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) ratio_seen <= {gear_pkg::NUM_RESET, gear_pkg::DEN_RESET};
      else if (cycle_tick_in) ratio_seen <= ratio_in;
   end
   a_pos_between_ticks: assert property (
      !cycle_tick_in |=> $stable(slave_pos_out)) else $error("position moved off tick");
   a_ingear_needs_src: assert property (
      master_source_in == gear_pkg::SRC_OFF && cycle_tick_in
      ##1 master_source_in == gear_pkg::SRC_OFF |-> !in_gear_out)
      else $error("in gear with no source");
   a_error_on_start: assert property (
      slave_start_in && master_source_in == gear_pkg::SRC_BUS_EXTR
      && sync_mode_in == gear_pkg::SYNC_OFF |-> ##[1:2] sync_error_out)
      else $error("missing sync error");
   a_error_clears: assert property (
      (sync_mode_in != gear_pkg::SYNC_OFF) [*2] |-> !sync_error_out)
      else $error("sync error kept");
   a_sync_event_mode1: assert property (
      (sync_mode_in == gear_pkg::SYNC_RX1 || sync_mode_in == gear_pkg::SYNC_TELEG)
      && bus_sync_in |-> ##[1:2] sync_event_out) else $error("no sync event");
   a_rx_event_mode23: assert property (
      (sync_mode_in == gear_pkg::SYNC_RX2 && bus_rx2_in)
      || (sync_mode_in == gear_pkg::SYNC_RX3 && bus_rx3_in) |-> ##[1:2] sync_event_out)
      else $error("no receive event");
   a_off_no_event: assert property (
      (sync_mode_in == gear_pkg::SYNC_OFF) [*3] |-> !sync_event_out)
      else $error("event with sync off");
   a_resync_drop: assert property (
      cycle_tick_in && ratio_change_resync_in && ratio_in != ratio_seen
      && master_source_in != gear_pkg::SRC_OFF |=> !in_gear_out)
      else $error("in gear kept on ratio change");
   a_ready_after_reset: assert property (
      $rose(arst_n_in) |-> bus_rx1_ready_out) else $error("not ready after reset");
endmodule
bind electronic_gear_phasing electronic_gear_phasing_properties
   electronic_gear_phasing_properties_i (
   .clk_in(clk_in), .arst_n_in(arst_n_in), .cycle_tick_in(cycle_tick_in),
   .master_source_in(master_source_in), .sync_mode_in(sync_mode_in), .ratio_in(ratio_in),
   .ratio_change_resync_in(ratio_change_resync_in), .slave_start_in(slave_start_in),
   .bus_rx2_in(bus_rx2_in), .bus_rx3_in(bus_rx3_in), .bus_sync_in(bus_sync_in),
   .bus_rx1_ready_out(bus_rx1_ready_out), .slave_pos_out(slave_pos_out),
   .in_gear_out(in_gear_out), .sync_error_out(sync_error_out),
   .sync_event_out(sync_event_out));

// >>> bench/electronic_gear_phasing_tb.sv
`timescale 1ns/1ps
module electronic_gear_phasing_tb;
   // ******************************
   // stimulus and checks
   // ******************************
   logic                     clk_in, arst_n_in, tick, resync, start_ph, slave_start;
   logic                     rx2, rx3, sync, rdy, vld, in_gear, done, err, evt, ok;
   logic [7:0]               src, mode;
   logic [31:0]              step, ramp_acc, word;
   logic signed [31:0]       pos, spd, p0;
   gear_pkg::gear_ratio_t    ratio;
   gear_pkg::phasing_cfg_t   ph;
   gear_pkg::master_sample_t enc1, enc2;
   int                       err_total, cmp_count, cyc;
   master_drive_model master_drive_model_i (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .tick_in(tick), .step_in(step),
      .enc1_out(enc1), .enc2_out(enc2), .word_out(word), .valid_out(vld), .ready_in(rdy));
   electronic_gear_phasing electronic_gear_phasing_i (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .cycle_tick_in(tick),
      .master_source_in(src), .sync_mode_in(mode), .ratio_in(ratio),
      .ratio_change_resync_in(resync), .ramp_accel_in(ramp_acc), .phasing_cfg_in(ph),
      .start_phasing_in(start_ph), .slave_start_in(slave_start), .enc1_in(enc1),
      .enc2_in(enc2), .bus_receive_object1_long_word_in(word), .bus_rx1_valid_in(vld),
      .bus_rx1_ready_out(rdy), .bus_rx2_in(rx2), .bus_rx3_in(rx3), .bus_sync_in(sync),
      .slave_pos_out(pos), .slave_spd_out(spd), .in_gear_out(in_gear),
      .phasing_done_out(done), .sync_error_out(err), .sync_event_out(evt));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   function automatic logic [31:0] exp_delta(input logic signed [15:0] n,
                                             input logic [15:0] d, input logic signed [31:0] s);
      return 32'((longint'(n) * longint'(s)) / longint'(d));
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (exp !== got) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge clk_in);
         #1 tick = 1'b1;
         @(posedge clk_in);
         #1 tick = 1'b0;
         repeat (3) @(posedge clk_in);
      end
      #1;
   endtask
   task automatic pulse(input logic [2:0] b);
      {rx2, rx3, sync} = b;
      @(posedge clk_in);
      #1 {rx2, rx3, sync} = 3'h0;
      repeat (2) @(posedge clk_in);
      #1;
   endtask
   task automatic gear_case(input logic [7:0] s, input logic signed [15:0] n,
                            input logic [15:0] d, input logic [31:0] k, input int settle);
      src = s;
      ratio = {n, d};
      step = k;
      tk(settle);
      p0 = pos;
      tk(1);
      chk("gear delta", exp_delta(n, d, k << (s == gear_pkg::SRC_ENC2)), pos - p0);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   initial begin
      logic signed [15:0] n;
      logic [15:0]        d;
      void'($urandom(32'h9e81));
      {arst_n_in, tick, resync, start_ph, slave_start, rx2, rx3, sync} = '0;
      src = gear_pkg::SRC_OFF;
      mode = gear_pkg::SYNC_OFF;
      ratio = {gear_pkg::NUM_RESET, gear_pkg::DEN_RESET};
      ph = {gear_pkg::PH_OFS_RESET, gear_pkg::PH_SPD_RESET, gear_pkg::PH_ACC_RESET};
      ramp_acc = 32'h32;
      step = 32'h0;
      repeat (4) @(posedge clk_in);
      #1 arst_n_in = 1'b1;
      chk("reset outputs", 32'h1, {26'h0, |{pos, spd}, in_gear, done, err, evt, rdy});
      for (int i = 0; i < 8; i++) begin
         n = 16'(int'($urandom_range(200, 0)) - 100);
         d = 16'($urandom_range(9, 1));
         gear_case(i[0] ? gear_pkg::SRC_ENC2 : gear_pkg::SRC_ENC1, n, d,
                   32'($urandom_range(50, 1)) * d, 3);
      end
      gear_case(gear_pkg::SRC_ENC1, gear_pkg::NUM_MAX, 16'hffff, 32'hffff, 3);
      gear_case(gear_pkg::SRC_ENC2, -16'sh7fff, 16'h1, 32'h1, 3);
      gear_case(gear_pkg::SRC_ENC2, 16'sh5, 16'h1, 32'h1, 0);
      $display("test gear done");
      src = gear_pkg::SRC_OFF;
      tk(1);
      p0 = pos;
      tk(3);
      chk("frozen position", p0, pos);
      chk("in gear off", 32'h0, {31'h0, in_gear});
      gear_case(gear_pkg::SRC_ENC1, 16'sh1, 16'h1, 32'h64, 3);
      resync = 1'b1;
      ratio = {16'sh3, 16'h1};
      tk(1);
      chk("ramp speed", 32'h96, spd);
      chk("in gear dropped", 32'h0, {31'h0, in_gear});
      tk(5);
      chk("ramped speed", 32'h12c, spd);
      chk("in gear again", 32'h1, {31'h0, in_gear});
      $display("test resync done");
      resync = 1'b0;
      gear_case(gear_pkg::SRC_ENC1, 16'sh1, 16'h1, 32'ha, 3);
      ph = {32'sh258, 32'h64, 32'h32};
      p0 = pos - enc1.pos;
      start_ph = 1'b1;
      tk(4);
      chk("phasing speed", 32'h6e, spd);
      for (int t = 0; t < 30 && done !== 1'b1; t++) tk(1);
      chk("phasing done", 32'h1, {31'h0, done});
      tk(2);
      chk("phase offset", 32'h258, pos - enc1.pos - p0);
      start_ph = 1'b0;
      tk(1);
      chk("done cleared", 32'h0, {31'h0, done});
      ph.offset = 32'sh186a0;
      start_ph = 1'b1;
      tk(4);
      start_ph = 1'b0;
      for (int t = 0; t < 30 && done !== 1'b1; t++) tk(1);
      chk("cancel done", 32'h1, {31'h0, done});
      chk("back to master", 32'ha, spd);
      $display("test phasing done");
      src = gear_pkg::SRC_BUS_EXTR;
      slave_start = 1'b1;
      @(posedge clk_in);
      #1 slave_start = 1'b0;
      repeat (2) @(posedge clk_in);
      chk("sync error", 32'h1, {31'h0, err});
      #1 mode = gear_pkg::SYNC_TELEG;
      repeat (2) @(posedge clk_in);
      chk("sync error cleared", 32'h0, {31'h0, err});
      #1;
      for (int i = 0; i < 16; i++) begin
         master_drive_model_i.send(32'(i), 4, ok);
         chk("fifo accept", 32'h1, {31'h0, ok});
      end
      chk("fifo full", 32'h0, {31'h0, rdy});
      master_drive_model_i.send(32'h5a5a, 3, ok);
      chk("fifo refuse", 32'h0, {31'h0, ok});
      repeat (16) pulse(3'h1);
      chk("fifo drained", 32'h1, {31'h0, rdy});
      for (int i = 0; i < 4; i++) begin
         mode = (i == 3) ? gear_pkg::SYNC_OFF : 8'(i + 1);
         for (int j = 0; j < 3; j++) pulse(3'h4 >> j);
      end
      $display("test sync done");
      mode = gear_pkg::SYNC_RX1;
      ratio = {gear_pkg::NUM_RESET, gear_pkg::DEN_RESET};
      for (int i = 0; i < 6; i++) begin
         p0 = pos;
         master_drive_model_i.send(32'h3e8 * i, 8, ok);
         tk(1);
      end
      chk("bus follow", 32'h3e8, pos - p0);
      $display("test bus done");
      complete_run();
   end
endmodule
